// ---- logic/adcc_conversion_control.sv ----
// Sequencer, registers and pin override of the 8-bit converter
//
// Notes on behaviour
// R01: Channel field picks one of fifteen inputs.
// R02: Every conversion yields an eight-bit result.
// R03: Store result, then flag or interrupt.
// R04: Selected pin forced to converter input.
// R05: Port writes ignored on selected pin.
// R06: Selected pin reads zero, or latch if output.
// R07: High reference all ones, ground all zeros.
// R08: Control write starts 16-17 tick conversion.
// R09: Continuous mode overwrites unread results.
// R10: Continuous repeats until its bit clears.
// R11: Flag stays set until write or read.
// R12: Interrupt enable allows request per conversion.
// R13: Request only while done bit is zero.
// R14: Converter keeps running during wait mode.
// R15: Software powers down before wait if unused.
// R16: Stop aborts conversion; resumes on exit.
// R17: Software allows settling after stop.
// R18: Software avoids timer clock shared channels.
// R19: All-ones channel switches converter off.
// R20: Prescaler divides by 1, 2, 4, 8, 16.
// R21: Clock source bit picks bus or oscillator.
//
// Chosen here: the strobed register port.
module adcc_conversion_control
  import adcc_pkg::*;
(
  input  wire logic [15:0] addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        write_i,
  input  wire logic        read_i,
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        oscillator_reference_clock_i,
  input  wire logic        comparator_i,
  input  wire logic        wait_mode_i,
  input  wire logic        stop_mode_i,
  input  wire logic [14:0] port_latch_i,
  input  wire logic [14:0] port_dir_i,
  input  wire logic [14:0] pin_i,
  output logic      [7:0]  rdata_o,
  output logic             irq_o,
  output logic      [7:0]  trial_code_o,
  output logic      [4:0]  selected_analog_input_o,
  output logic             converter_on_o,
  output logic             converting_o,
  output logic      [14:0] pin_out_o,
  output logic      [14:0] pin_oe_o,
  output logic      [14:0] port_read_o
);

  typedef struct packed {
    logic [7:0]    rdata;
    logic          done;
    logic          ien;
    logic          cont;
    logic [4:0]    ch;
    logic [2:0]    div;
    logic          clksel;
    logic [7:0]    result;
    logic [7:0]    sar;
    logic [3:0]    tick_cnt;
    adcc_mode_type mode;
    logic          resume;
    logic          stop_prev;
    logic          irq_pend;
    logic          irq;
    logic [1:0]    osc_sync;
    logic          osc_prev;
    logic [1:0]    cmp_sync;
    logic [14:0]   pin_s1;
    logic [14:0]   pin_s2;
    logic [14:0]   pin_out;
    logic [14:0]   pin_oe;
    logic [14:0]   port_rd;
    logic          conv_on;
    logic          busy;
  } adcc_state_type;

  adcc_state_type q;
  adcc_state_type d;

  // Internal strobes, register decode and pin select
  logic        adc_tick;
  logic        src_tick;
  logic        start;
  logic        prescale_run;
  logic        scr_wr;
  logic        clk_wr;
  logic        scr_rd;
  logic        data_rd;
  logic        clk_rd;
  logic [14:0] ch_hot;

  // Bit under trial for a given tick count, MSB first
  function automatic logic [2:0] adcc_bit(input logic [3:0] cnt);
    return 3'(ADCC_RES_BITS - 1) - cnt[3:1];
  endfunction

  function automatic logic adcc_hit(input logic [15:0] a, input logic [15:0] ofs);
    return a == ofs;
  endfunction

  // All-ones channel code powers the converter down
  function automatic logic adcc_off(input logic [4:0] ch);
    return ch == ADCC_CH_OFF;
  endfunction

  // One-hot pin select; codes above fourteen pick no pin
  function automatic logic [14:0] adcc_onehot(input logic [4:0] ch);
    logic [14:0] hot;
    hot = 15'h0000;
    for (int i = 0; i < ADCC_NCH; i++) begin
      hot[i] = (ch == 5'(i));
    end
    return hot;
  endfunction

  // Unmapped reads give zero; data register writes are dropped
  assign scr_wr  = write_i && adcc_hit(addr_i, ADCC_SCR_OFS);
  assign clk_wr  = write_i && adcc_hit(addr_i, ADCC_CLK_OFS);
  assign scr_rd  = read_i && adcc_hit(addr_i, ADCC_SCR_OFS);
  assign data_rd = read_i && adcc_hit(addr_i, ADCC_DATA_OFS);
  assign clk_rd  = read_i && adcc_hit(addr_i, ADCC_CLK_OFS);
  assign ch_hot  = adcc_onehot(q.ch);

  // R21 bus clock or oscillator edge
  // Edge counted, so oscillator duty cycle does not matter
  assign src_tick = q.clksel ? 1'b1 : (q.osc_sync[1] & ~q.osc_prev);

  // R19 no start while powered off
  assign start = scr_wr && !adcc_off(wdata_i[ADCC_SCR_CH_MSB:ADCC_SCR_CH_LSB])
                 && !stop_mode_i;

  assign prescale_run = (q.mode == ADCC_CONV) && !stop_mode_i;

  // Cleared on every start so a restart waits a full tick
  adcc_prescaler u_prescaler (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .run_i      (prescale_run),
    .clear_i    (start),
    .src_tick_i (src_tick),
    .div_i      (q.div),
    .tick_o     (adc_tick)
  );

  always_comb begin
    logic [2:0] b;
    logic       sel;
    logic       fin;
    b   = 3'h0;
    sel = 1'b0;
    fin = 1'b0;
    d   = q;

    // Pin and oscillator synchronisers
    // Nothing reads a first stage except its second stage
    d.osc_sync = {q.osc_sync[0], oscillator_reference_clock_i};
    d.osc_prev = q.osc_sync[1];
    d.cmp_sync = {q.cmp_sync[0], comparator_i};
    d.pin_s1   = pin_i;
    d.pin_s2   = q.pin_s1;
    d.stop_prev = stop_mode_i;

    // Read data stand for one cycle only
    d.rdata = 8'h00;
    if (scr_rd) begin
      d.rdata = {q.done, q.ien, q.cont, q.ch};
    end
    if (data_rd) begin
      d.rdata = q.result;
      // R11 data read clears flag
      if (!q.ien) begin
        d.done = 1'b0;
      end
      d.irq_pend = 1'b0;
    end
    if (clk_rd) begin
      d.rdata = {q.div, q.clksel, 4'h0};
    end

    if (scr_wr) begin
      d.ien  = wdata_i[ADCC_SCR_IEN_BIT];
      d.cont = wdata_i[ADCC_SCR_CONT_BIT];
      d.ch   = wdata_i[ADCC_SCR_CH_MSB:ADCC_SCR_CH_LSB];
      // R13 done bit writable only with interrupts
      d.done = q.ien ? wdata_i[ADCC_SCR_DONE_BIT] : 1'b0;
      d.irq_pend = 1'b0;
      d.resume   = 1'b0;
      // R19 off code aborts a conversion unless a resume after stop lands in the same cycle
      if (adcc_off(d.ch)) begin
        d.mode = ADCC_IDLE;
      end
    end
    // No guard: a divider change mid-conversion skews that result
    if (clk_wr) begin
      d.div    = wdata_i[ADCC_CLK_DIV_MSB:ADCC_CLK_DIV_LSB];
      d.clksel = wdata_i[ADCC_CLK_SEL_BIT];
    end

    // R08 write starts a fresh conversion
    if (start) begin
      d.mode     = ADCC_CONV;
      d.tick_cnt = 4'h0;
      d.sar      = 8'h00;
    end else if (stop_mode_i) begin
      // R16 stop aborts, remember to resume
      // Trial bits are lost, so the resumed run starts over
      if (q.mode == ADCC_CONV) begin
        d.resume = 1'b1;
      end
      d.mode = ADCC_IDLE;
    end else if (q.stop_prev && q.resume && !adcc_off(q.ch)) begin
      // R16 resume after stop exit
      d.resume   = 1'b0;
      d.mode     = ADCC_CONV;
      d.tick_cnt = 4'h0;
      d.sar      = 8'h00;
    end else if (q.mode == ADCC_CONV && adc_tick) begin
      // R14 runs on regardless of wait mode
      b = adcc_bit(q.tick_cnt);
      if (!q.tick_cnt[0]) begin
        d.sar[b] = 1'b1;
      end else begin
        // R07 keep bit while input at or above trial
        // Comparator seen two cycles late; divide by one is marginal
        d.sar[b] = q.cmp_sync[1];
      end
      d.tick_cnt = q.tick_cnt + 4'h1;
      fin = (q.tick_cnt == ADCC_LAST_TICK);
    end

    if (fin) begin
      // R02 eight-bit result
      // R09 overwrite regardless of reads
      d.result = d.sar;
      d.sar    = 8'h00;
      // R10 back to back while continuous
      // A same-cycle power-down write must still stop it
      d.mode = (d.cont && !adcc_off(d.ch)) ? ADCC_CONV : ADCC_IDLE;
      // R03 flag or request after storing
      if (q.ien) begin
        // R12 request per completed conversion
        d.irq_pend = 1'b1;
      end else begin
        // R11 set wins over same-cycle clear
        d.done = 1'b1;
      end
    end

    // Level request, held until software clears it
    // R13 request gated by done bit low
    d.irq = d.ien && d.irq_pend && !d.done;

    // R19 converter power
    d.conv_on = !adcc_off(d.ch);
    // Busy flag kept in a flop so the output needs no decode
    d.busy    = (d.mode == ADCC_CONV);

    for (int i = 0; i < ADCC_NCH; i++) begin
      // R01 R04 selected channel pin override
      sel = ch_hot[i];
      // R05 port writes have no effect here
      d.pin_oe[i]  = sel ? 1'b0 : port_dir_i[i];
      d.pin_out[i] = port_latch_i[i];
      // R06 zero or latch on selected pin
      if (port_dir_i[i]) begin
        d.port_rd[i] = port_latch_i[i];
      end else begin
        d.port_rd[i] = sel ? 1'b0 : q.pin_s2[i];
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      // Status fields from their packed reset value
      q <= '0;
      q.ch <= ADCC_SCR_RESET[ADCC_SCR_CH_MSB:ADCC_SCR_CH_LSB];
      q.done <= ADCC_SCR_RESET[ADCC_SCR_DONE_BIT];
      q.ien <= ADCC_SCR_RESET[ADCC_SCR_IEN_BIT];
      q.cont <= ADCC_SCR_RESET[ADCC_SCR_CONT_BIT];
      q.div <= ADCC_DIV_RESET;
      q.clksel <= ADCC_SEL_RESET;
      q.mode <= ADCC_IDLE;
    end else begin
      q <= d;
    end
  end

  assign rdata_o                 = q.rdata;
  assign irq_o                   = q.irq;
  assign trial_code_o            = q.sar;
  assign selected_analog_input_o = q.ch;
  assign converter_on_o          = q.conv_on;
  assign converting_o            = q.busy;
  assign pin_out_o               = q.pin_out;
  assign pin_oe_o                = q.pin_oe;
  assign port_read_o             = q.port_rd;

endmodule // adcc_conversion_control

// ---- logic/adcc_prescaler.sv ----
// Converter clock prescaler producing a one-cycle tick enable
module adcc_prescaler
  import adcc_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       run_i,
  input  wire logic       clear_i,
  input  wire logic       src_tick_i,
  input  wire logic [2:0] div_i,
  output logic            tick_o
);

  typedef struct packed {
    logic [3:0] cnt;
    logic       tick;
  } adcc_pre_type;

  adcc_pre_type q;
  adcc_pre_type d;

  function automatic logic [3:0] adcc_last(input logic [2:0] code);
    logic [4:0] ratio;
    ratio = code[2] ? ADCC_MAX_DIV : (5'h01 << code[1:0]);
    return 4'(ratio - 5'h01);
  endfunction

  always_comb begin
    d      = q;
    d.tick = 1'b0;
    if (!run_i || clear_i) begin
      d.cnt = 4'h0;
    end else if (src_tick_i) begin
      // R20 divide by 1/2/4/8/16
      if (q.cnt >= adcc_last(div_i)) begin
        d.cnt  = 4'h0;
        d.tick = 1'b1;
      end else begin
        d.cnt = q.cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tick_o = q.tick;

endmodule // adcc_prescaler

// ---- pkg/adcc_pkg.sv ----
// Package of constants and types for the converter control block
package adcc_pkg;

  localparam int unsigned ADCC_AW = 16;
  localparam int unsigned ADCC_DW = 8;
  localparam int unsigned ADCC_NCH = 15;
  localparam int unsigned ADCC_CHW = 5;

  // Register byte addresses
  localparam logic [15:0] ADCC_SCR_OFS  = 16'h0038;
  localparam logic [15:0] ADCC_DATA_OFS = 16'h0039;
  localparam logic [15:0] ADCC_CLK_OFS  = 16'h003A;

  // Status and control field positions
  localparam int unsigned ADCC_SCR_DONE_BIT = 7;
  localparam int unsigned ADCC_SCR_IEN_BIT  = 6;
  localparam int unsigned ADCC_SCR_CONT_BIT = 5;
  localparam int unsigned ADCC_SCR_CH_MSB   = 4;
  localparam int unsigned ADCC_SCR_CH_LSB   = 0;

  // Clock register field positions
  localparam int unsigned ADCC_CLK_DIV_MSB = 7;
  localparam int unsigned ADCC_CLK_DIV_LSB = 5;
  localparam int unsigned ADCC_CLK_SEL_BIT = 4;

  // Reset values
  localparam logic [4:0] ADCC_CH_OFF    = 5'h1F;
  localparam logic [7:0] ADCC_SCR_RESET = 8'h1F;
  localparam logic [2:0] ADCC_DIV_RESET = 3'h0;
  localparam logic       ADCC_SEL_RESET = 1'b0;

  // Conversion timing in converter clock ticks
  localparam int unsigned ADCC_RES_BITS   = 8;
  localparam int unsigned ADCC_CONV_TICKS = 16;
  localparam logic [3:0]  ADCC_LAST_TICK  = 4'(ADCC_CONV_TICKS - 1);
  localparam logic [4:0]  ADCC_MAX_DIV    = 5'h10;

  typedef enum logic [1:0] {
    ADCC_IDLE = 2'b00,
    ADCC_CONV = 2'b01
  } adcc_mode_type;

endpackage

// ---- verification/adcc_ctrl_assertions.sv ----
// Concurrent checks on the converter control block ports
module adcc_ctrl_assertions
  import adcc_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0]  wdata_i,
  input wire logic        write_i,
  input wire logic        read_i,
  input wire logic        stop_mode_i,
  input wire logic        irq_o,
  input wire logic [4:0]  selected_analog_input_o,
  input wire logic        converter_on_o,
  input wire logic        converting_o,
  input wire logic [14:0] pin_oe_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic scr_wr;
  assign scr_wr = write_i && addr_i == ADCC_SCR_OFS;
  property p_off; converter_on_o == (selected_analog_input_o != ADCC_CH_OFF); endproperty
  a_off: assert property (p_off) else $error("power flag wrong");
  // Stable channel only, since the enable may lag a channel change
  property p_oe; selected_analog_input_o < 5'h0F && $stable(selected_analog_input_o)
    |-> !pin_oe_o[selected_analog_input_o[3:0]]; endproperty
  a_oe: assert property (p_oe) else $error("selected pin driven");
  property p_start; scr_wr && wdata_i[4:0] != ADCC_CH_OFF && !stop_mode_i |=> converting_o;
  endproperty
  a_start: assert property (p_start) else $error("no start");
  property p_stop; stop_mode_i |=> !converting_o; endproperty
  a_stop: assert property (p_stop) else $error("stop did not abort");
  property p_irq; $rose(irq_o) |-> $past(converting_o); endproperty
  a_irq: assert property (p_irq) else $error("request without completion");
  property p_rdclr; irq_o && !converting_o && read_i && addr_i == ADCC_DATA_OFS |=> !irq_o;
  endproperty
  a_rdclr: assert property (p_rdclr) else $error("request not cleared");
  property p_done; scr_wr && wdata_i[7] && !converting_o |=> !irq_o; endproperty
  a_done: assert property (p_done) else $error("request with done bit set");
  property p_len; $fell(converting_o) && !$past(stop_mode_i) && !$past(write_i)
    |-> $past(converting_o, 16); endproperty
  a_len: assert property (p_len) else $error("conversion too short");
endmodule // adcc_ctrl_assertions
bind adcc_conversion_control adcc_ctrl_assertions u_chk (.clk_i, .rst_i, .addr_i, .wdata_i,
  .write_i, .read_i, .stop_mode_i, .irq_o, .selected_analog_input_o, .converter_on_o,
  .converting_o, .pin_oe_o);

// ---- verification/tb_top.sv ----
// Self-checking bench for the converter control block
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, (a), (b)); end end
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import adcc_pkg::*;
  logic        clk_i = 0, rst_i = 1, write_i = 0, read_i = 0, comparator_i = 0;
  logic        oscillator_reference_clock_i = 0, wait_mode_i = 0, stop_mode_i = 0;
  logic [15:0] addr_i = '0;
  logic [7:0]  wdata_i = '0, rdata_o, trial_code_o, v;
  logic [14:0] port_latch_i = 15'h7FFF, port_dir_i = 15'h00FF, pin_i = 15'h7FFF;
  logic [14:0] pin_out_o, pin_oe_o, port_read_o;
  logic [4:0]  selected_analog_input_o;
  logic        irq_o, converter_on_o, converting_o;
  int          num_errors = 0, checks = 0, cyc;
  logic [2:0]  dv [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h7};
  int          rt [6] = '{1, 2, 4, 8, 16, 16};
  always #2 clk_i = ~clk_i;
  // Unrelated in phase to the bus clock on purpose
  always #7 oscillator_reference_clock_i = ~oscillator_reference_clock_i;
  adcc_conversion_control u_dut (.addr_i, .wdata_i, .write_i, .read_i, .clk_i, .rst_i,
    .oscillator_reference_clock_i, .comparator_i, .wait_mode_i, .stop_mode_i,
    .port_latch_i, .port_dir_i, .pin_i, .rdata_o, .irq_o, .trial_code_o,
    .selected_analog_input_o, .converter_on_o, .converting_o, .pin_out_o,
    .pin_oe_o, .port_read_o);
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    write_i <= 1'b1;
    @(posedge clk_i);
    write_i <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    read_i <= 1'b1;
    @(posedge clk_i);
    read_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  // Counts busy cycles; a hang is cut at the limit
  task automatic conv(input int lim);
    cyc = 0;
    #1;
    while (converting_o === 1'b1 && cyc < lim) begin
      @(posedge clk_i);
      #1 cyc++;
    end
    if (cyc >= lim) num_errors++;
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #100000;
    num_errors++;
    close_out;
  end
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(ADCC_SCR_OFS, v);
    `CHK(v, 8'h1F)
    rd(ADCC_CLK_OFS, v);
    `CHK(v, 8'h00)
    rd(16'h003B, v);
    `CHK(v, 8'h00)
    `CHK(converter_on_o, 1'b0)
    `CHK(selected_analog_input_o, ADCC_CH_OFF)
    for (int k = 0; k < 6; k++) begin
      @(posedge clk_i);
      comparator_i <= k[0];
      wr(ADCC_CLK_OFS, {dv[k], 5'h10});
      wr(ADCC_SCR_OFS, 8'h03);
      conv(400);
      `CHK(cyc >= 16 * rt[k] && cyc <= 17 * rt[k] + 1, 1'b1)
      rd(ADCC_SCR_OFS, v);
      `CHK(v, 8'h83)
      rd(ADCC_DATA_OFS, v);
      `CHK(v, k[0] ? 8'hFF : 8'h00)
      rd(ADCC_SCR_OFS, v);
      `CHK(v, 8'h03)
    end
    wr(ADCC_CLK_OFS, 8'h00);
    wr(ADCC_SCR_OFS, 8'h04);
    conv(400);
    `CHK(cyc > 50 && cyc < 70, 1'b1)
    `CHK(pin_oe_o, 15'h00EF)
    `CHK(port_read_o[4], 1'b1)
    `CHK(selected_analog_input_o, 5'h04)
    @(posedge clk_i);
    port_latch_i <= 15'h7FEF;
    wr(ADCC_SCR_OFS, 8'h09);
    repeat (3) @(posedge clk_i);
    #1;
    `CHK(port_read_o, 15'h7DEF)
    `CHK(pin_oe_o, 15'h00FF)
    `CHK(pin_out_o, 15'h7FEF)
    conv(400);
    wr(ADCC_CLK_OFS, 8'h30);
    @(posedge clk_i);
    wait_mode_i <= 1'b1;
    wr(ADCC_SCR_OFS, 8'h02);
    repeat (4) @(posedge clk_i);
    #1 `CHK(trial_code_o, 8'h80)
    @(posedge clk_i);
    stop_mode_i <= 1'b1;
    @(posedge clk_i);
    #1;
    `CHK(converting_o, 1'b0)
    @(posedge clk_i);
    stop_mode_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    conv(400);
    `CHK(cyc >= 30, 1'b1)
    rd(ADCC_SCR_OFS, v);
    `CHK(v, 8'h82)
    @(posedge clk_i);
    wait_mode_i <= 1'b0;
    wr(ADCC_SCR_OFS, 8'h21);
    repeat (40) @(posedge clk_i);
    comparator_i <= 1'b0;
    repeat (80) @(posedge clk_i);
    #1;
    `CHK(converting_o, 1'b1)
    rd(ADCC_SCR_OFS, v);
    `CHK(v, 8'hA1)
    rd(ADCC_DATA_OFS, v);
    `CHK(v, 8'h00)
    wr(ADCC_SCR_OFS, 8'h1F);
    #1;
    `CHK(converting_o | converter_on_o, 1'b0)
    wr(ADCC_SCR_OFS, 8'h45);
    conv(100);
    `CHK(irq_o, 1'b1)
    rd(ADCC_DATA_OFS, v);
    `CHK(irq_o, 1'b0)
    wr(ADCC_SCR_OFS, 8'hC5);
    conv(100);
    `CHK(irq_o, 1'b0)
    wr(ADCC_SCR_OFS, 8'h1F);
    wait_mode_i <= 1'b1;
    #1 `CHK(converter_on_o, 1'b0)
    close_out;
  end
endmodule // tb_top
